//--- dv/fcp_cpu_model.sv
// cpu model issuing flash command writes and reads
`timescale 1ns/10ps
`default_nettype none
module fcp_cpu_model (
  // clock
  input wire logic clk_in,
  // cpu strobes toward the block
  output logic wr_out,
  output logic rd_out,
  output logic [23:0] addr_out,
  output logic [15:0] wdata_out,
  output logic fetch_out,
  // read data back
  input wire logic [15:0] rdata_in
);
  // idle bus at time zero
  initial begin
    {wr_out, rd_out, fetch_out} = 3'h0;
    addr_out = 24'h000000;
    wdata_out = 16'h0000;
  end
  // one write; the address is a pointer value, never a direct operand
  task automatic cpu_write(input logic [23:0] a, input logic [15:0] d, input logic f);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    fetch_out = f;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    fetch_out = 1'b0;
    // released bus shows the inverse so stale values never pass
    addr_out = ~a;
    wdata_out = ~d;
  endtask : cpu_write
  // one read; data is taken one cycle after the strobe
  task automatic cpu_read(input logic [23:0] a, output logic [15:0] d);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    addr_out = ~a;
    d = rdata_in;
  endtask : cpu_read
endmodule : fcp_cpu_model
`default_nettype wire

//--- dv/flash_command_protect_map_tb.sv
// self-checking bench for the flash command and protection map block
`timescale 1ns/10ps
`default_nettype none
module flash_command_protect_map_tb;
  import fcp_pkg::*;
  // --------
  // signals
  // --------
  logic clk, reset_n, wr, rd, fetch, blk, boot, ext, lreq, cfg, ien, rmp, sgd;
  logic cpa, werr, sus, res, unl, ien_o, rmp_o, sgd_o, hit, rlen, rpin;
  logic [23:0] addr, phys, a;
  logic [15:0] wdata, arr, rdata, prot, pexp, d;
  logic [7:0] fsr;
  logic [31:0] seed = 32'hF35D;
  logic [31:0] r;
  logic [23:0] edges [0:4] = '{24'h007FFE, 24'h008000, 24'h017FFE, 24'h04FFFE, 24'h050000};
  int miscompares = 0;
  int total_checks = 0;
  // --------
  // design and cpu partner
  // --------
  fcp_flash_cmd u_fcp_flash_cmd (.clk_in(clk), .reset_n_in(reset_n), .wr_in(wr), .rd_in(rd),
    .addr_in(addr), .wdata_in(wdata), .fetch_from_flash_in(fetch), .block_addr_wr_in(blk),
    .array_rdata_in(arr), .boot_select_pin_in(boot), .external_start_in(ext),
    .reset_lengthen_req_in(lreq), .cfg_wr_in(cfg), .internal_memory_enable_in(ien),
    .segment_remap_bit_in(rmp), .segmentation_disable_in(sgd), .rdata_out(rdata),
    .flash_status_register_out(fsr), .protection_register_out(prot), .code_protect_active_out(cpa),
    .write_error_out(werr), .erase_suspend_cmd_out(sus), .erase_resume_cmd_out(res),
    .block_temp_unlock_cmd_out(unl), .internal_memory_enable_out(ien_o),
    .segment_remap_bit_out(rmp_o), .segmentation_disable_out(sgd_o), .flash_phys_addr_out(phys),
    .flash_hit_out(hit), .reset_lengthen_out(rlen), .reset_pin_drive_out(rpin));
  fcp_cpu_model u_fcp_cpu_model (.clk_in(clk), .wr_out(wr), .rd_out(rd), .addr_out(addr),
    .wdata_out(wdata), .fetch_out(fetch), .rdata_in(rdata));
  // --------
  // helpers
  // --------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // flash window: upper fixed part plus the movable lowest 32K
  function automatic logic hit_exp(input logic [23:0] x, input logic rm);
    return (x >= 24'h018000 && x < 24'h050000) || (rm ? x < 24'h008000 : (x >= 24'h010000 && x < 24'h018000));
  endfunction : hit_exp
  // lowest 32K seen at segment 1 folds back to flash offset zero
  function automatic logic [23:0] phys_exp(input logic [23:0] x, input logic rm);
    return (!rm && x >= FCP_SEG1_BASE && x < 24'h018000) ? x - FCP_SEG1_BASE : x;
  endfunction : phys_exp
  task automatic check(input string n, input logic [23:0] s, input logic [23:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic done(input string n);
    $display("test %s done", n);
  endtask : done
  // command write, random bits above A13 and in the high byte
  task automatic cmd(input logic [13:0] x, input logic [7:0] c);
    logic [31:0] q;
    q = rnd();
    u_fcp_cpu_model.cpu_write({q[9:0], x}, {q[31:24], c}, 1'b0);
  endtask : cmd
  task automatic prefix(input logic [7:0] s, input int gap);
    cmd(FCP_PROT_ADDR1, FCP_PREFIX1_DATA);
    idle(gap);
    cmd(FCP_PROT_ADDR2, FCP_PREFIX2_DATA);
    idle(gap);
    cmd(FCP_PROT_ADDR1, s);
  endtask : prefix
  // protection word to a random odd word address
  task automatic word_wr(input logic [15:0] w);
    logic [31:0] q;
    q = rnd();
    u_fcp_cpu_model.cpu_write({q[23:2], FCP_ODD_WORD_LOW}, w, 1'b0);
    idle(2);
  endtask : word_wr
  task automatic cfg_set(input logic e, input logic m, input logic s);
    @(negedge clk);
    {ien, rmp, sgd, cfg} = {e, m, s, 1'b1}; // issued as if from internal ram
    @(negedge clk);
    cfg = 1'b0;
    idle(1); // gap stands for the jump and page pointer reload
  endtask : cfg_set
  // clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    final_report();
  end
  // --------
  // main sequence
  // --------
  initial begin
    {reset_n, blk, ext, lreq, cfg, ien, rmp, sgd} = 8'h00;
    r = rnd();
    boot = r[0];
    arr = r[31:16];
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    idle(8);
    check("prot reset", prot, FCP_PROT_RESET);
    check("enable latch", ien_o, boot);
    check("remap reset", rmp_o, 1'b1);
    check("segdis reset", sgd_o, 1'b1);
    done("reset");
    repeat (6) begin
      r = rnd();
      u_fcp_cpu_model.cpu_write(r[23:0], {r[31:24], FCP_SUSPEND_DATA}, 1'b0);
      check("suspend", sus, 1'b1);
      u_fcp_cpu_model.cpu_write(r[31:8], {r[7:0], FCP_RESUME_DATA}, 1'b0);
      check("suspend end", sus, 1'b0);
      check("resume", res, 1'b1);
    end
    done("suspend");
    r = rnd();
    pexp = {1'b0, r[14:0]};
    prefix(FCP_SETPROT_DATA, 3);
    u_fcp_cpu_model.cpu_read(24'h000006, d);
    check("dummy read", d, FCP_DUMMY_DATA);
    word_wr(pexp);
    check("prot", prot, pexp);
    check("code prot", cpa, 1'b1);
    check("no error", werr, 1'b0);
    prefix(FCP_SETPROT_DATA, 0);
    word_wr(16'hFFFF);
    check("error", werr, 1'b1);
    check("prot kept", prot, pexp);
    r = rnd();
    prefix(FCP_SETPROT_DATA, 1);
    word_wr(pexp & r[15:0]);
    pexp = pexp & r[15:0];
    check("error cleared", werr, 1'b0);
    check("prot lower", prot, pexp);
    done("protect");
    prefix(FCP_READPROT_DATA, 0);
    repeat (2) begin
      r = rnd();
      u_fcp_cpu_model.cpu_read({r[23:2], FCP_ODD_WORD_LOW}, d);
      check("prot read", d, pexp);
    end
    cmd(14'h0000, FCP_READRESET_DATA);
    u_fcp_cpu_model.cpu_read({r[23:2], FCP_ODD_WORD_LOW}, d);
    check("array after write", d, arr);
    cmd(FCP_PROT_ADDR1, FCP_PREFIX1_DATA);
    cmd(FCP_PROT_ADDR2, 8'h55);
    u_fcp_cpu_model.cpu_read(24'h000002, d);
    check("array after break", d, arr);
    cmd(FCP_PROT_ADDR1, FCP_SETPROT_DATA);
    word_wr(16'h0000);
    check("prot untouched", prot, pexp);
    prefix(FCP_BLKUNLOCK_DATA, 1);
    cmd(14'(rnd()), FCP_READRESET_DATA);
    check("block unlock", unl, 1'b1);
    done("sequences");
    for (int m = 0; m < 2; m++) begin
      cfg_set(1'b1, m[0], 1'b0);
      check("enable", ien_o, 1'b1);
      check("remap", rmp_o, m[0]);
      check("segdis", sgd_o, 1'b0);
      for (int k = 0; k < 14; k++) begin
        r = rnd();
        a = k < 5 ? edges[k] : {5'h00, r[18:0]};
        u_fcp_cpu_model.cpu_read(a, d);
        check("hit", hit, hit_exp(a, m[0]));
        check("phys", phys, phys_exp(a, m[0]));
      end
    end
    cfg_set(1'b0, 1'b1, 1'b0);
    u_fcp_cpu_model.cpu_read(24'h020000, d);
    check("hit disabled", hit, 1'b0);
    cfg_set(1'b1, 1'b1, 1'b0);
    done("map");
    // unlock and relock count only when fetched from flash
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      u_fcp_cpu_model.cpu_write({8'h02, r[15:0]}, i < 2 ? FCP_CODE_UNLOCK_DATA : FCP_CODE_RELOCK_DATA, i[0]);
      idle(1);
      check("code prot", cpa, i == 0 || i == 3);
    end
    done("code lock");
    // second block address restarts the window
    for (int j = 0; j < 2; j++) begin
      @(negedge clk);
      blk = 1'b1;
      @(negedge clk);
      blk = 1'b0;
      idle(1000);
    end
    idle(FCP_BLOCK_WINDOW_CYC - 1020);
    check("window open", fsr[FCP_WINDOW_STATUS_BIT], 1'b0);
    idle(30);
    check("window expired", fsr[FCP_WINDOW_STATUS_BIT], 1'b1);
    done("window");
    {ext, lreq} = 2'h3;
    idle(4);
    check("no lengthen", rlen, 1'b0);
    check("reset pin", rpin, 1'b0);
    ext = 1'b0;
    idle(2);
    check("lengthen", rlen, 1'b1);
    check("reset pin held", rpin, 1'b0);
    done("reset lengthen");
    final_report();
  end
endmodule : flash_command_protect_map_tb
`default_nettype wire

//--- include/fcp_pkg.sv
// shared constants for the flash command and protection map block
package fcp_pkg;
  // ----------------------------------------------------------------
  // command data codes (low byte; code unlock and relock compare the full 16-bit word)
  // ----------------------------------------------------------------
  localparam logic [7:0] FCP_SUSPEND_DATA = 8'hB0;
  localparam logic [7:0] FCP_RESUME_DATA = 8'h30;
  localparam logic [7:0] FCP_PREFIX1_DATA = 8'hA8;
  localparam logic [7:0] FCP_PREFIX2_DATA = 8'h54;
  localparam logic [7:0] FCP_SETPROT_DATA = 8'hC0;
  localparam logic [7:0] FCP_READPROT_DATA = 8'h90;
  localparam logic [7:0] FCP_BLKUNLOCK_DATA = 8'hC1;
  localparam logic [7:0] FCP_READRESET_DATA = 8'hF0;
  localparam logic [15:0] FCP_CODE_UNLOCK_DATA = 16'hFFFF;
  localparam logic [15:0] FCP_CODE_RELOCK_DATA = 16'hFFFB;
  // ----------------------------------------------------------------
  // command addresses, only A13..A0 decoded
  // ----------------------------------------------------------------
  localparam int FCP_CMD_ADDR_BITS = 14;
  localparam logic [13:0] FCP_PROT_ADDR1 = 14'h2A54;
  localparam logic [13:0] FCP_PROT_ADDR2 = 14'h15A8;
  localparam logic [1:0] FCP_ODD_WORD_LOW = 2'h2;
  // ----------------------------------------------------------------
  // protection word layout and resets
  // ----------------------------------------------------------------
  localparam int FCP_CODE_PROT_BIT = 15;
  localparam logic [15:0] FCP_PROT_RESET = 16'hFFFF;
  localparam int FCP_WINDOW_STATUS_BIT = 3;
  localparam logic [7:0] FCP_STATUS_RESET = 8'h00;
  localparam logic [15:0] FCP_DUMMY_DATA = 16'h0000;
  // ----------------------------------------------------------------
  // mapping
  // ----------------------------------------------------------------
  localparam logic [23:0] FCP_SEG1_BASE = 24'h010000;
  localparam logic [23:0] FCP_LOW32K_SIZE = 24'h008000;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int FCP_CLK_HZ = 20000000;
  localparam int FCP_BLOCK_WINDOW_US = 96;
  localparam int FCP_BLOCK_WINDOW_CYC = (FCP_BLOCK_WINDOW_US * (FCP_CLK_HZ / 1000000));
  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FCP_IDLE = 3'b000,
    FCP_GOT1 = 3'b001,
    FCP_GOT2 = 3'b010,
    FCP_SETP = 3'b011,
    FCP_BLKUNLOCK = 3'b100,
    FCP_READP = 3'b101
  } fcp_state_type;
endpackage : fcp_pkg

//--- include/fcp_win_if.sv
// interface between sequencer and the block-erase window timer
`timescale 1ns/10ps
`default_nettype none
interface fcp_win_if;
  logic restart;
  logic open;
  modport owner (output restart, input open);
  modport timer (input restart, output open);
endinterface : fcp_win_if
`default_nettype wire

//--- rtl/fcp_flash_cmd.sv
// flash command decoder, protection register and map controls
`timescale 1ns/10ps
`default_nettype none
// Operation
// - one write of B0 to any address suspends the running erase
// - one write of 30 to any address resumes a suspended erase
// - protection commands: A8 at 2A54, 54 at 15A8, selector at 2A54
// - written word zero at bit 15 protects code, bit N protects block N; code_protect_active_out follows only the code lock, not bit 15
// - protection bits only clear; restoring a one flags a write error
// - selector 90 makes odd word reads return protection register until next write
// - command address decode ignores A14 and above
// - each block address opens 96 us window; expiry shown in status bit 3
// - FFFF unlocks, FFFB relocks code, only when written by flash-fetched code
// - gaps between cycles tolerated; unused cycles read dummy data
// - reset lengthening not shown on reset pin, skipped on external start
// - boot pin latched into internal memory enable on the third clock after reset release
// - remap bit moves only the lowest 32K; other flash unaffected
// - segmentation disable must be zero for full 256K use; the map here decodes all 256K whatever seg_dis holds
module fcp_flash_cmd
  import fcp_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // cpu write and read strobes
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [23:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic fetch_from_flash_in,
  input wire logic block_addr_wr_in,
  input wire logic [15:0] array_rdata_in,
  // pins and starts
  input wire logic boot_select_pin_in,
  input wire logic external_start_in,
  input wire logic reset_lengthen_req_in,
  // system configuration writes
  input wire logic cfg_wr_in,
  input wire logic internal_memory_enable_in,
  input wire logic segment_remap_bit_in,
  input wire logic segmentation_disable_in,
  // read data and status
  output logic [15:0] rdata_out,
  output logic [7:0] flash_status_register_out,
  output logic [15:0] protection_register_out,
  output logic code_protect_active_out,
  output logic write_error_out,
  // erase control
  output logic erase_suspend_cmd_out,
  output logic erase_resume_cmd_out,
  output logic block_temp_unlock_cmd_out,
  // map and reset
  output logic internal_memory_enable_out,
  output logic segment_remap_bit_out,
  output logic segmentation_disable_out,
  output logic [23:0] flash_phys_addr_out,
  output logic flash_hit_out,
  output logic reset_lengthen_out,
  output logic reset_pin_drive_out
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  fcp_state_type state, next_state;
  logic boot_meta, boot_sync;
  logic [1:0] boot_age;
  logic [15:0] protection_register;
  logic code_locked;
  logic [15:0] rdata;
  logic [7:0] status;
  logic write_error;
  logic suspend_p, resume_p, blk_unlock_p;
  logic rom_en, remap, seg_dis;
  logic [23:0] phys;
  logic hit;
  logic lengthen;
  fcp_win_if win ();

  fcp_window_timer u_window (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .win(win)
  );

  // ----------------------------------------------------------------
  // address and data decode
  // ----------------------------------------------------------------
  wire [13:0] cmd_addr = addr_in[FCP_CMD_ADDR_BITS-1:0];
  wire at_a1 = (cmd_addr == FCP_PROT_ADDR1);
  wire at_a2 = (cmd_addr == FCP_PROT_ADDR2);
  wire odd_word = (addr_in[1:0] == FCP_ODD_WORD_LOW);
  wire [7:0] wlo = wdata_in[7:0];
  // sequences from flash-fetched code are not commands, except the two code writes
  wire cmd_wr = wr_in && !fetch_from_flash_in;
  wire code_wr = wr_in && fetch_from_flash_in;
  wire is_unlock = code_wr && (wdata_in == FCP_CODE_UNLOCK_DATA);
  wire is_relock = code_wr && (wdata_in == FCP_CODE_RELOCK_DATA);
  wire in_idle = (state == FCP_IDLE);
  wire do_suspend = cmd_wr && in_idle && (wlo == FCP_SUSPEND_DATA);
  wire do_resume = cmd_wr && in_idle && (wlo == FCP_RESUME_DATA);
  wire do_setp = cmd_wr && (state == FCP_SETP) && odd_word;
  // only bits that are ones may change to zero
  wire raise_bit = |(wdata_in & ~protection_register);
  wire do_blk_unlock = cmd_wr && (state == FCP_BLKUNLOCK) && (wlo == FCP_READRESET_DATA);

  // ----------------------------------------------------------------
  // sequencer next state; a write off the expected path aborts
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (cmd_wr) begin
      case (state)
        FCP_IDLE: begin
          next_state = (at_a1 && wlo == FCP_PREFIX1_DATA) ? FCP_GOT1 : FCP_IDLE;
        end
        FCP_GOT1: begin
          next_state = (at_a2 && wlo == FCP_PREFIX2_DATA) ? FCP_GOT2 : FCP_IDLE;
        end
        FCP_GOT2: begin
          if (at_a1 && wlo == FCP_SETPROT_DATA) begin
            next_state = FCP_SETP;
          end else if (at_a1 && wlo == FCP_READPROT_DATA) begin
            next_state = FCP_READP;
          end else if (at_a1 && wlo == FCP_BLKUNLOCK_DATA) begin
            next_state = FCP_BLKUNLOCK;
          end else begin
            next_state = FCP_IDLE;
          end
        end
        FCP_READP: begin
          next_state = FCP_IDLE;
        end
        default: begin
          next_state = FCP_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register; idle gaps simply hold the state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= FCP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // protection register and code lock
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      protection_register <= FCP_PROT_RESET;
      write_error <= 1'b0;
      code_locked <= 1'b1;
    end else begin
      if (do_setp) begin
        protection_register <= protection_register & wdata_in;
        write_error <= raise_bit;
      end else if (cmd_wr && in_idle && at_a1 && wlo == FCP_PREFIX1_DATA) begin
        write_error <= 1'b0;
      end
      if (is_unlock) begin
        code_locked <= 1'b0;
      end else if (is_relock) begin
        code_locked <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // one-cycle command pulses and read data
  // ----------------------------------------------------------------
  wire prot_read = rd_in && (state == FCP_READP) && odd_word;
  wire seq_busy = (state == FCP_GOT1) || (state == FCP_GOT2) || (state == FCP_SETP) || (state == FCP_BLKUNLOCK);
  wire [15:0] next_rdata = prot_read ? protection_register :
                           (rd_in && seq_busy) ? FCP_DUMMY_DATA : array_rdata_in;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      suspend_p <= 1'b0;
      resume_p <= 1'b0;
      blk_unlock_p <= 1'b0;
      rdata <= FCP_DUMMY_DATA;
    end else begin
      suspend_p <= do_suspend;
      resume_p <= do_resume;
      blk_unlock_p <= do_blk_unlock;
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // block window status, bit set when the window has expired
  // ----------------------------------------------------------------
  assign win.restart = block_addr_wr_in;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status <= FCP_STATUS_RESET;
    end else begin
      status <= FCP_STATUS_RESET;
      status[FCP_WINDOW_STATUS_BIT] <= !win.open;
    end
  end

  // ----------------------------------------------------------------
  // boot pin sync and latch once after reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      boot_meta <= 1'b0;
      boot_sync <= 1'b0;
      boot_age <= 2'h0;
      rom_en <= 1'b0;
      remap <= 1'b1;
      seg_dis <= 1'b1;
    end else begin
      boot_meta <= boot_select_pin_in;
      boot_sync <= boot_meta;
      // pin is taken once, only after both sync stages hold it
      if (boot_age != 2'h3) begin
        boot_age <= boot_age + 2'h1;
      end
      if (boot_age == 2'h2) begin
        rom_en <= boot_sync;
      end else if (cfg_wr_in) begin
        rom_en <= internal_memory_enable_in;
      end
      if (cfg_wr_in) begin
        remap <= segment_remap_bit_in;
        seg_dis <= segmentation_disable_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // address map: remap moves only the lowest 32K
  // ----------------------------------------------------------------
  wire low_blk = (addr_in < FCP_LOW32K_SIZE);
  wire seg1_low = (addr_in >= FCP_SEG1_BASE) && (addr_in < (FCP_SEG1_BASE + FCP_LOW32K_SIZE));
  wire upper_area = (addr_in >= (FCP_SEG1_BASE + FCP_LOW32K_SIZE)) && (addr_in < 24'h050000);
  wire low_hit = remap ? low_blk : seg1_low;
  wire next_hit = rom_en && (low_hit || upper_area);
  wire [23:0] next_phys = low_hit ? {9'h000, addr_in[14:0]} : addr_in;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phys <= 24'h000000;
      hit <= 1'b0;
    end else begin
      phys <= next_phys;
      hit <= next_hit;
    end
  end

  // ----------------------------------------------------------------
  // reset lengthening, internal only, never on the pin
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lengthen <= 1'b0;
    end else begin
      lengthen <= reset_lengthen_req_in && !external_start_in;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_out = rdata;
  assign flash_status_register_out = status;
  assign protection_register_out = protection_register;
  assign code_protect_active_out = code_locked;
  assign write_error_out = write_error;
  assign erase_suspend_cmd_out = suspend_p;
  assign erase_resume_cmd_out = resume_p;
  assign block_temp_unlock_cmd_out = blk_unlock_p;
  assign internal_memory_enable_out = rom_en;
  assign segment_remap_bit_out = remap;
  assign segmentation_disable_out = seg_dis;
  assign flash_phys_addr_out = phys;
  assign flash_hit_out = hit;
  assign reset_lengthen_out = lengthen;
  assign reset_pin_drive_out = 1'b0;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_SUSPEND: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    do_suspend |=> suspend_p) else $error("suspend pulse missing");
  AST_RESUME: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    resume_p |-> $past(cmd_wr) && $past(wlo) == FCP_RESUME_DATA) else $error("resume without write");
  AST_PREFIX: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (state == FCP_GOT1 && cmd_wr && !at_a2) |=> state == FCP_IDLE) else $error("prefix not aborted");
  AST_MONOTONIC: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ##1 ((protection_register & ~$past(protection_register)) == 16'h0000)) else $error("protection bit rose");
  AST_WRERR: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (do_setp && raise_bit) |=> write_error) else $error("write error not flagged");
  AST_SETP: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    do_setp |=> protection_register == ($past(protection_register) & $past(wdata_in))) else $error("bad set");
  AST_READP: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    prot_read |=> rdata == $past(protection_register)) else $error("protection read wrong");
  AST_CODELOCK: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (wr_in && !fetch_from_flash_in) |=> code_locked == $past(code_locked)) else $error("lock changed from ram");
  AST_PIN: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    external_start_in |=> !lengthen && !reset_pin_drive_out) else $error("lengthen on external start");
endmodule : fcp_flash_cmd
`default_nettype wire

//--- rtl/fcp_window_timer.sv
// block-erase address window timer
`timescale 1ns/10ps
`default_nettype none
module fcp_window_timer
  import fcp_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // window control
  fcp_win_if.timer win
);
  logic [11:0] count;
  logic open_q;
  localparam logic [11:0] LOAD = 12'(FCP_BLOCK_WINDOW_CYC);
  // ----------------------------------------------------------------
  // countdown, restarted by each block address write
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count <= 12'h000;
      open_q <= 1'b0;
    end else if (win.restart) begin
      count <= LOAD;
      open_q <= 1'b1;
    end else if (count != 12'h000) begin
      count <= count - 12'h001;
      open_q <= (count != 12'h001);
    end
  end
  assign win.open = open_q;
  // window still open 8 cycles after a restart with no further restart
  AST_WINDOW_LEN: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    win.restart ##1 (!win.restart) [*8] |-> open_q) else $error("window closed early");
endmodule : fcp_window_timer
`default_nettype wire
